// file: verilog/cmc_mode_ctrl.sv
// Function
// RL1: soft start caps input current at min(200mA,limit)
// RL2: battery switch off when charging disabled; code still turns it on in boost, in supplement, or with the converter stopped
// RL3: pulse-skip default on, disable bit turns off; code clears it only with system out of regulation or in boost
// RL4: high impedance request enters high impedance state
// RL5: boost level from four-way select, 5V default
// RL6: boost only when all enable conditions hold
// RL7: report code 111 while boosting
// RL8: input blocking switch off during boost
// RL9: auto switch charge and boost on adapter
// RL10: flag minimum system regulation
// RL11: reduce charge current on input overload
// RL12: flag limiting input voltage/current loop
// RL13: supplement mode when system below battery
// RL14: leave supplement below depletion threshold
// RL15: default charge parameters, host may overwrite
// RL16: start charge only when all conditions hold
// RL17: terminate on low current, no regulation
// RL18: recharge when battery below recharge threshold
// RL19: restart on enable toggle or adapter replug
// RL20: status pin low charging, high done, blinking fault
// RL21: phase code 00/01/10/11
// RL22: interrupt pulse on charge completion
// RL23: blink status pin at 1Hz on timer fault
// RL24: status reads reflect present state
`timescale 1ns/10ps
`include "cmc_regs.svh"
module cmc_mode_ctrl
   import cmc_pkg::*;
#(
   parameter int BLINK_HALF = `CMC_BLINK_HALF
)(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire cmc_sense_t  sense,
   output logic             battery_switch,
   output logic             input_blocking_switch,
   output logic             internal_regulator,
   output logic             boost_enable,
   output logic [1:0]       boost_voltage_select,
   output logic             pulse_skip_enable,
   output logic [15:0]      input_current_cap,
   output logic             charge_reduce,
   output logic             charge_status_pin,
   output logic             host_interrupt_n,
   output logic             high_impedance_state
);

   cmc_st_t r_reg;
   cmc_st_t r_next;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            m[i*8 +: 8] = d[i*8 +: 8];
      return m;
   endfunction : merge

   logic       chg_en;
   logic       bst_en;
   logic       bsw_dis;
   logic       start_ok;
   logic       boost_ok;
   logic       term_ok;
   logic       trig;
   logic       aw_fire;
   logic       w_fire;
   logic       ar_fire;
   logic [15:0] iin_lim;
   cmc_sense_t s;

   always_comb
   begin
      r_next = r_reg;
      s = r_reg.s2;
      chg_en = r_reg.ctrl[`CMC_CTRL_CHG_EN];
      bst_en = r_reg.ctrl[`CMC_CTRL_BST_EN];
      bsw_dis = r_reg.ctrl[`CMC_CTRL_BSW_DIS];
      iin_lim = r_reg.limits[15:0];
      // pins pass two flops before use
      r_next.s1 = sense;
      r_next.s2 = r_reg.s1;

      // bus slave: address and data taken in either order
      aw_fire = s_axi_awvalid && !r_reg.bus.awdone && !r_reg.bus.bvalid;
      w_fire = s_axi_wvalid && !r_reg.bus.wdone && !r_reg.bus.bvalid;
      if (aw_fire)
      begin
         r_next.bus.awdone = 1'b1;
         r_next.bus.awaddr = s_axi_awaddr;
      end
      if (w_fire)
      begin
         r_next.bus.wdone = 1'b1;
         r_next.bus.wdata = s_axi_wdata;
         r_next.bus.wstrb = s_axi_wstrb;
      end
      if (r_reg.bus.awdone && r_reg.bus.wdone)
      begin
         r_next.bus.awdone = 1'b0;
         r_next.bus.wdone = 1'b0;
         r_next.bus.bvalid = 1'b1;
         r_next.bus.bresp = 2'h0;
         case (r_reg.bus.awaddr[11:2])
            10'(`CMC_OFF_CTRL >> 2):
               r_next.ctrl = merge(r_reg.ctrl, r_reg.bus.wdata, r_reg.bus.wstrb);
            10'(`CMC_OFF_CHGPARAM >> 2): // RL15
               r_next.chgparam = merge(r_reg.chgparam, r_reg.bus.wdata, r_reg.bus.wstrb);
            10'(`CMC_OFF_LIMITS >> 2):
               r_next.limits = merge(r_reg.limits, r_reg.bus.wdata, r_reg.bus.wstrb);
            10'(`CMC_OFF_STATUS >> 2):
               r_next.bus.bresp = 2'h0;
            default:
               r_next.bus.bresp = 2'h2;
         endcase
      end
      if (r_reg.bus.bvalid && s_axi_bready)
         r_next.bus.bvalid = 1'b0;

      ar_fire = s_axi_arvalid && !r_reg.bus.rvalid;
      if (ar_fire)
      begin
         r_next.bus.rvalid = 1'b1;
         r_next.bus.rresp = 2'h0;
         case (s_axi_araddr[11:2])
            10'(`CMC_OFF_CTRL >> 2):     r_next.bus.rdata = r_reg.ctrl;
            10'(`CMC_OFF_CHGPARAM >> 2): r_next.bus.rdata = r_reg.chgparam;
            10'(`CMC_OFF_LIMITS >> 2):   r_next.bus.rdata = r_reg.limits;
            10'(`CMC_OFF_STATUS >> 2): // RL24
               r_next.bus.rdata = {16'h0000, 4'h0, r_reg.state, r_reg.supplement,
                                   r_reg.iloop, r_reg.vloop, r_reg.minsys,
                                   r_reg.phase, r_reg.src};
            default:
            begin
               r_next.bus.rdata = 32'h0000_0000;
               r_next.bus.rresp = 2'h2;
            end
         endcase
      end
      else if (r_reg.bus.rvalid && s_axi_rready)
         r_next.bus.rvalid = 1'b0;

      // start, boost and termination qualifiers
      start_ok = s.conv_running && chg_en && (r_reg.chgparam[15:0] != 16'h0000) // RL16
                 && !s.chg_en_pin_n && (!s.ts_fault || r_reg.ctrl[`CMC_CTRL_TS_IGN])
                 && !s.timer_fault && !bsw_dis;
      boost_ok = !bsw_dis && !chg_en && bst_en && s.bat_above_boost_min // RL6
                 && s.vbus_below_sleep && (s.ts_boost_ok || r_reg.ctrl[`CMC_CTRL_TS_IGN]);
      // with both bits set, adapter absence lets boost follow automatically
      if (chg_en && bst_en && !s.adapter) // RL9
         boost_ok = !bsw_dis && s.bat_above_boost_min && s.vbus_below_sleep
                    && (s.ts_boost_ok || r_reg.ctrl[`CMC_CTRL_TS_IGN]);
      term_ok = s.charge_current_setting_below_term && s.bat_above_recharge && !s.iin_over // RL17
                && !s.vin_under && !s.thermal_reg;
      // a toggle of either enable or an adapter replug restarts after done
      trig = chg_en && !s.chg_en_pin_n;
      r_next.trig_prev = trig;
      r_next.adapter_prev = s.adapter;

      case (r_reg.state)
         CMC_IDLE:
            if (s.adapter && r_reg.ctrl[`CMC_CTRL_HIZ_REQ])
               r_next.state = CMC_HIZ; // RL4
            else if (s.adapter && start_ok)
               r_next.state = CMC_CHARGE; // RL9
            else if (!s.adapter && boost_ok)
               r_next.state = CMC_BOOST;
         CMC_CHARGE:
            if (!s.adapter || !start_ok)
               r_next.state = s.timer_fault ? CMC_FAULT : CMC_IDLE;
            else if (r_reg.ctrl[`CMC_CTRL_HIZ_REQ])
               r_next.state = CMC_HIZ;
            else if (term_ok)
            begin
               r_next.state = CMC_DONE;
               r_next.irq_cnt = `CMC_IRQ_PULSE; // RL22
            end
         CMC_DONE:
            if (!s.adapter || (trig && !r_reg.trig_prev)) // RL19
               r_next.state = CMC_IDLE;
            else if (!s.bat_above_recharge && start_ok)
               r_next.state = CMC_CHARGE; // RL18
            else if (r_reg.ctrl[`CMC_CTRL_HIZ_REQ])
               r_next.state = CMC_HIZ;
         CMC_BOOST:
            if (s.adapter || !boost_ok)
               r_next.state = CMC_IDLE; // RL9
         CMC_HIZ:
            if (!s.adapter || !r_reg.ctrl[`CMC_CTRL_HIZ_REQ])
               r_next.state = CMC_IDLE;
         CMC_FAULT:
            if (!s.adapter || !s.timer_fault)
               r_next.state = CMC_IDLE;
         default:
            r_next.state = CMC_IDLE;
      endcase

      // supplement mode entry and exit
      if (s.charge_current_setting_zero && s.sys_below_bat && s.conv_running)
         r_next.supplement = 1'b1; // RL13
      if (!s.bat_above_depletion)
         r_next.supplement = 1'b0; // RL14

      // battery switch: on while charging, supplementing, or no converter
      r_next.bat_switch = ((r_reg.state == CMC_CHARGE) && chg_en) // RL2
                          || r_reg.supplement || (!s.conv_running && !bsw_dis
                                                 && s.bat_above_depletion);
      if (r_reg.state == CMC_BOOST)
         r_next.bat_switch = 1'b1;

      r_next.boost_on = (r_reg.state == CMC_BOOST);
      r_next.rbfet_on = s.adapter && (r_reg.state != CMC_BOOST) // RL8
                        && (r_reg.state != CMC_HIZ); // RL4
      r_next.internal_regulator_on = (r_reg.state != CMC_HIZ) && (s.adapter || r_reg.state == CMC_BOOST);
      r_next.pfm_on = !(r_reg.ctrl[`CMC_CTRL_PULSE_SKIP_DISABLE] // RL3
                        && (!s.sys_in_reg || r_reg.state == CMC_BOOST));
      r_next.iin_cap = (s.sys_below_short && iin_lim > `CMC_SOFTSTART_MA) // RL1
                       ? `CMC_SOFTSTART_MA : iin_lim;
      r_next.chg_reduce = s.iin_over || s.vin_under; // RL11
      r_next.iloop = s.iin_over; // RL12
      r_next.vloop = s.vin_under; // RL12
      r_next.minsys = s.sys_at_min; // RL10
      r_next.src = (r_reg.state == CMC_BOOST) ? `CMC_SRC_BOOST // RL7
                   : (s.adapter ? `CMC_SRC_ADAPTER : `CMC_SRC_NONE);

      case (r_reg.state) // RL21
         CMC_CHARGE: r_next.phase = s.bat_above_lowv ? 2'b10 : 2'b01;
         CMC_DONE:   r_next.phase = 2'b11;
         default:    r_next.phase = 2'b00;
      endcase

      // 1 Hz blink generator, free running so it starts in phase with nothing
      if (r_reg.blink_cnt >= 32'(BLINK_HALF - 1))
      begin
         r_next.blink_cnt = 32'h0000_0000;
         r_next.blink = !r_reg.blink; // RL23
      end
      else
         r_next.blink_cnt = r_reg.blink_cnt + 32'h0000_0001;
      case (r_reg.state) // RL20
         CMC_CHARGE: r_next.stat_pin = 1'b0;
         CMC_FAULT:  r_next.stat_pin = r_reg.blink; // RL23
         default:    r_next.stat_pin = 1'b1;
      endcase

      if (r_reg.irq_cnt != 8'h00)
         r_next.irq_cnt = r_reg.irq_cnt - 8'h01;
      r_next.irq_n = (r_reg.irq_cnt == 8'h00); // RL22
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r_reg <= '0;
         r_reg.ctrl <= `CMC_CTRL_RESET;
         r_reg.chgparam <= `CMC_CHGPARAM_RESET; // RL15
         r_reg.limits <= `CMC_LIMITS_RESET;
         r_reg.state <= CMC_IDLE;
         r_reg.irq_n <= 1'b1;
         r_reg.stat_pin <= 1'b1;
         r_reg.pfm_on <= 1'b1;
         r_reg.s1.chg_en_pin_n <= 1'b1;
         r_reg.s2.chg_en_pin_n <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign s_axi_awready = !r_reg.bus.awdone && !r_reg.bus.bvalid;
   assign s_axi_wready = !r_reg.bus.wdone && !r_reg.bus.bvalid;
   assign s_axi_bvalid = r_reg.bus.bvalid;
   assign s_axi_bresp = r_reg.bus.bresp;
   assign s_axi_arready = !r_reg.bus.rvalid;
   assign s_axi_rvalid = r_reg.bus.rvalid;
   assign s_axi_rdata = r_reg.bus.rdata;
   assign s_axi_rresp = r_reg.bus.rresp;
   assign battery_switch = r_reg.bat_switch;
   assign input_blocking_switch = r_reg.rbfet_on;
   assign internal_regulator = r_reg.internal_regulator_on;
   assign boost_enable = r_reg.boost_on;
   assign boost_voltage_select = r_reg.ctrl[`CMC_CTRL_BOOST_VOLTAGE_SELECT_LSB +: 2]; // RL5
   assign pulse_skip_enable = r_reg.pfm_on;
   assign input_current_cap = r_reg.iin_cap;
   assign charge_reduce = r_reg.chg_reduce;
   assign charge_status_pin = r_reg.stat_pin;
   assign host_interrupt_n = r_reg.irq_n;
   assign high_impedance_state = (r_reg.state == CMC_HIZ);

endmodule : cmc_mode_ctrl

// file: verilog/cmc_regs.svh
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH
// register byte offsets on the AXI4-Lite bus
`define CMC_OFF_CTRL      12'h000
`define CMC_OFF_CHGPARAM  12'h004
`define CMC_OFF_LIMITS    12'h008
`define CMC_OFF_STATUS    12'h00C
// control register fields
`define CMC_CTRL_CHG_EN     0
`define CMC_CTRL_BST_EN     1
`define CMC_CTRL_HIZ_REQ    2
`define CMC_CTRL_BSW_DIS    3
`define CMC_CTRL_PULSE_SKIP_DISABLE    4
`define CMC_CTRL_TS_IGN     5
`define CMC_CTRL_RECHG_SEL  6
`define CMC_CTRL_BMIN_SEL   7
`define CMC_CTRL_BOOST_VOLTAGE_SELECT_LSB 8
`define CMC_CTRL_RESET      32'h0000_0201
// charge parameters in mV / mA / hours
`define CMC_CHGPARAM_RESET  32'h0A3C_0154
`define CMC_VREG_MV         16'h1068
`define CMC_PRECHG_MA       8'h28
// limits: input current limit mA low half, input voltage limit mV high half
`define CMC_LIMITS_RESET    32'h1194_01F4
`define CMC_SOFTSTART_MA    16'h00C8
// input source codes reported in the status register: boosting, no source, adapter
`define CMC_SRC_BOOST       3'h7
`define CMC_SRC_NONE        3'h0
`define CMC_SRC_ADAPTER     3'h3
// blink: 1 Hz, toggle every 500 ms at 50 MHz
`define CMC_CLK_HZ          32'h02FA_F080
`define CMC_BLINK_HALF      (`CMC_CLK_HZ / 2)
`define CMC_IRQ_PULSE       8'h32
`endif

// file: verilog/cmc_pkg.sv
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_IDLE   = 3'b000,
      CMC_CHARGE = 3'b001,
      CMC_DONE   = 3'b011,
      CMC_BOOST  = 3'b010,
      CMC_HIZ    = 3'b110,
      CMC_FAULT  = 3'b111
   } cmc_state_t;

   typedef struct packed {
      logic adapter;
      logic conv_running;
      logic sys_below_short;
      logic sys_in_reg;
      logic sys_below_bat;
      logic sys_at_min;
      logic bat_above_boost_min;
      logic bat_above_depletion;
      logic bat_above_recharge;
      logic bat_above_lowv;
      logic charge_current_setting_below_term;
      logic charge_current_setting_zero;
      logic iin_over;
      logic vin_under;
      logic ts_fault;
      logic ts_boost_ok;
      logic timer_fault;
      logic thermal_reg;
      logic vbus_below_sleep;
      logic chg_en_pin_n;
   } cmc_sense_t;

   typedef struct packed {
      logic        awdone;
      logic        wdone;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cmc_bus_t;

   typedef struct packed {
      cmc_bus_t    bus;
      logic [31:0] ctrl;
      logic [31:0] chgparam;
      logic [31:0] limits;
      cmc_sense_t  s1;
      cmc_sense_t  s2;
      cmc_state_t  state;
      logic        trig_prev;
      logic        adapter_prev;
      logic        supplement;
      logic        bat_switch;
      logic        blink;
      logic [31:0] blink_cnt;
      logic [7:0]  irq_cnt;
      logic        irq_n;
      logic        stat_pin;
      logic [1:0]  phase;
      logic [2:0]  src;
      logic        pfm_on;
      logic        rbfet_on;
      logic        internal_regulator_on;
      logic        boost_on;
      logic [15:0] iin_cap;
      logic        chg_reduce;
      logic        vloop;
      logic        iloop;
      logic        minsys;
   } cmc_st_t;
endpackage : cmc_pkg

// file: bench/cmc_mode_ctrl_chk.sv
`timescale 1ns/10ps
module cmc_mode_ctrl_chk
   import cmc_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire cmc_sense_t  sense,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        battery_switch,
   input wire logic        input_blocking_switch,
   input wire logic        internal_regulator,
   input wire logic        boost_enable,
   input wire logic [15:0] input_current_cap,
   input wire logic        charge_reduce,
   input wire logic        host_interrupt_n,
   input wire logic        high_impedance_state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_boost_blocks_input: assert property (
      boost_enable[*2] |-> !input_blocking_switch) else $error("input switch on in boost");
   a_hiz_all_off: assert property (
      high_impedance_state[*2] |-> !internal_regulator && !input_blocking_switch)
      else $error("regulator or input switch on in high impedance");
   a_soft_start_cap: assert property (
      sense.sys_below_short[*6] |-> input_current_cap <= 16'h00C8) else $error("soft cap");
   a_irq_pulse_len: assert property (
      $fell(host_interrupt_n) |-> !host_interrupt_n[*8]) else $error("interrupt too short");
   a_overload_reduce: assert property (
      (sense.adapter && sense.conv_running && (sense.iin_over || sense.vin_under))[*6]
      |-> charge_reduce) else $error("no charge reduction on overload");
   a_supplement_on: assert property (
      (sense.adapter && sense.charge_current_setting_zero && sense.sys_below_bat && sense.bat_above_depletion)[*6]
      |-> battery_switch) else $error("battery switch off in supplement");
   a_boost_needs_low_vbus: assert property (
      (!sense.vbus_below_sleep)[*6] |-> !boost_enable) else $error("boost with input high");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_unmapped_zero: assert property (
      s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
      else $error("refused read carries data");
endmodule : cmc_mode_ctrl_chk

bind cmc_mode_ctrl cmc_mode_ctrl_chk u_chk (.clk, .srst, .sense, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .battery_switch, .input_blocking_switch,
   .internal_regulator, .boost_enable, .input_current_cap, .charge_reduce, .host_interrupt_n,
   .high_impedance_state);

// file: bench/cmc_host_model.sv
`timescale 1ns/10ps
module cmc_host_model
(
   input wire logic  clk,
   output logic [11:0] s_axi_awaddr,
   output logic        s_axi_awvalid,
   input wire logic    s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input wire logic    s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic    s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic        s_axi_arvalid,
   input wire logic    s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic    s_axi_rvalid,
   output logic        s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end

   // write: drives address and data together, then waits up to 64 cycles for the write response
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64)
         tb.timed_out();
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64)
         tb.timed_out();
   endtask : rd
endmodule : cmc_host_model

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
   import cmc_pkg::*;
   logic clk, srst;
   cmc_sense_t sense, sn;
   int n_mismatch, tests_run, k;
   logic [31:0] rv;
   logic [1:0] rr;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, boost_voltage_select;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, boost_enable, charge_reduce;
   logic battery_switch, input_blocking_switch, internal_regulator, pulse_skip_enable;
   logic charge_status_pin, host_interrupt_n, high_impedance_state, last;
   logic [15:0] input_current_cap;

   cmc_mode_ctrl #(.BLINK_HALF(8)) DUT (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense, .battery_switch,
      .input_blocking_switch, .internal_regulator, .boost_enable, .boost_voltage_select,
      .pulse_skip_enable, .input_current_cap, .charge_reduce, .charge_status_pin,
      .host_interrupt_n, .high_impedance_state);
   cmc_host_model host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   task automatic timed_out;
      n_mismatch++;
      final_report();
   endtask : timed_out

   // sense goes through two sync flops, state and output flops: 8 cycles covers it
   task automatic apply;
      @(posedge clk);
      sense <= sn;
      repeat (8) @(posedge clk);
   endtask : apply

   task automatic ctl(input logic [31:0] d);
      host.wr(12'h000, d, rr);
      repeat (6) @(posedge clk);
   endtask : ctl

   task automatic stat;
      host.rd(12'h00C, rv, rr);
   endtask : stat

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      timed_out();
   end

   initial
   begin
      srst = 1'b1;
      sn = '0;
      sense = '0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      host.rd(12'h000, rv, rr);
      chk(rv, 32'h0000_0201);
      host.rd(12'h004, rv, rr);
      chk(rv, 32'h0A3C_0154);
      host.rd(12'h008, rv, rr);
      chk(rv, 32'h1194_01F4);
      chk(boost_voltage_select, 2'b10);
      chk(pulse_skip_enable, 1'b1);
      host.rd(12'h010, rv, rr);
      chk({rr, rv}, {2'b10, 32'h0000_0000});
      {sn.adapter, sn.conv_running, sn.sys_below_short, sn.sys_in_reg} = 4'hF;
      {sn.bat_above_depletion, sn.ts_boost_ok, sn.bat_above_boost_min} = 3'h7;
      apply();
      chk(input_current_cap, 16'h00C8);
      host.wr(12'h008, 32'h1194_0064, rr);
      repeat (6) @(posedge clk);
      chk(input_current_cap, 16'h0064);
      sn.sys_below_short = 1'b0;
      apply();
      host.wr(12'h008, 32'h1194_01F4, rr);
      repeat (6) @(posedge clk);
      chk(input_current_cap, 16'h01F4);
      stat();
      chk({rv[4:3], charge_status_pin, battery_switch}, 4'b0101);
      {sn.bat_above_lowv, sn.sys_at_min, sn.vin_under, sn.iin_over} = 4'hF;
      apply();
      stat();
      chk({rv[7:3], charge_reduce}, 6'b111101);
      {sn.sys_at_min, sn.vin_under, sn.iin_over, sn.charge_current_setting_zero, sn.sys_below_bat} = 5'h03;
      apply();
      stat();
      chk({rv[8:5], charge_reduce, battery_switch}, 6'b100001);
      sn.bat_above_depletion = 1'b0;
      apply();
      stat();
      chk(rv[8], 1'b0);
      {sn.bat_above_depletion, sn.charge_current_setting_zero, sn.sys_below_bat} = 3'h4;
      {sn.charge_current_setting_below_term, sn.bat_above_recharge, sn.thermal_reg} = 3'h7;
      apply();
      stat();
      chk({rv[4:3], host_interrupt_n}, 3'b101);
      sn.thermal_reg = 1'b0;
      apply();
      stat();
      chk({rv[4:3], charge_status_pin, host_interrupt_n}, 4'b1110);
      {sn.charge_current_setting_below_term, sn.bat_above_recharge} = 2'b00;
      apply();
      stat();
      chk(rv[4:3], 2'b10);
      sn.bat_above_recharge = 1'b1;
      apply();
      ctl(32'h0000_0200);
      stat();
      chk({rv[4:3], charge_status_pin, battery_switch}, 4'b0010);
      ctl(32'h0000_0201);
      stat();
      chk(rv[4:3], 2'b10);
      sn.timer_fault = 1'b1;
      apply();
      last = charge_status_pin;
      k = 0;
      repeat (40)
      begin
         @(posedge clk);
         k += (charge_status_pin !== last);
         last = charge_status_pin;
      end
      chk(k >= 4, 1'b1);
      {sn.timer_fault, sn.adapter, sn.vbus_below_sleep} = 3'b001;
      apply();
      for (int v = 0; v < 4; v++)
      begin
         ctl({22'h0, v[1:0], 8'h02});
         chk({boost_voltage_select, boost_enable, input_blocking_switch}, {v[1:0], 2'b10});
      end
      stat();
      chk(rv[2:0], 3'b111);
      sn.bat_above_boost_min = 1'b0;
      apply();
      chk(boost_enable, 1'b0);
      sn.bat_above_boost_min = 1'b1;
      apply();
      ctl(32'h0000_0203);
      chk(boost_enable, 1'b1);
      {sn.adapter, sn.vbus_below_sleep, sn.sys_in_reg} = 3'b100;
      apply();
      stat();
      chk({boost_enable, rv[4:3]}, 3'b010);
      ctl(32'h0000_0213);
      chk(pulse_skip_enable, 1'b0);
      ctl(32'h0000_0207);
      chk({high_impedance_state, internal_regulator, input_blocking_switch}, 3'b100);
      final_report();
   end
endmodule : tb
